// *** src/analog_comparator_control_map.svh ***
`ifndef ANALOG_COMPARATOR_CONTROL_MAP_SVH
`define ANALOG_COMPARATOR_CONTROL_MAP_SVH

// Positive-input source codes of a comparator control setting.
`define SRC_OWN_PIN 2'h0
`define SRC_CMP0_PIN 2'h1
`define SRC_REFERENCE 2'h2

// Edge or level sense codes, shared by interrupt and trigger settings.
`define SENSE_LEVEL 2'h0
`define SENSE_FALL 2'h1
`define SENSE_RISE 2'h2
`define SENSE_BOTH 2'h3

// Ladder geometry in unit resistors.
`define LADDER_LO_TOTAL 5'h1F
`define LADDER_LO_OFFSET 5'h08
`define LADDER_HI_TOTAL 5'h17
`define RANGE_HIGH 1'h1

// Factor used when a path is not scaled, and the ladder reset values.
`define UNITY_FACTOR 5'h01
`define LADDER_NUM_RESET 5'h00
`define LADDER_DEN_RESET 5'h01

// Reset value of every status, flag and output bit.
`define FLAG_RESET 1'h0
`define PAIR_RESET 2'h0

`endif

// *** src/analog_comparator_control_pkg.sv ***
`default_nettype none
package analog_comparator_control_pkg;

    // Settings of one comparator, driven by software-owned bits.
    typedef struct packed {
        logic [1:0] positive_source_select; // Source of the positive input.
        logic invert;                       // Inverts the reported result.
        logic [1:0] irq_sense;              // Interrupt edge or level.
        logic irq_level;                    // Active level in level mode.
        logic [1:0] trig_sense;             // Trigger edge or level.
        logic trig_level;                   // Active level in level mode.
        logic trig_en;                      // Lets events reach the trigger.
        logic pin_en;                       // Enables the output pin of comparator 0; unused for comparator 1.
    } comparator_ctl_type;

    // Settings of the shared reference ladder.
    typedef struct packed {
        logic en;                     // Powers the ladder.
        logic reference_range_select; // Selects the 23 R ladder when set.
        logic [3:0] tap;              // Ladder tap, 0 to 15.
    } reference_ctl_type;

endpackage
`default_nettype wire

// *** src/comparator_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "analog_comparator_control_map.svh"

// One comparator: decision, polarity, and separate event sensing.
module comparator_channel
    import analog_comparator_control_pkg::*;
#(
    parameter int SW = 17
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [SW-1:0] lhs,
    input wire logic [SW-1:0] rhs,
    input wire comparator_ctl_type ctl,
    output logic result_r,
    output logic irq_evt_r,
    output logic trig_r
);

    logic prev_r; // Result one cycle earlier, for edge detection.
    logic rise;   // Result went from 0 to 1.
    logic fall;   // Result went from 1 to 0.

    // Decides whether an event of the given sense is present now.
    function automatic logic sense_hit(input logic [1:0] sense,
                                       input logic level,
                                       input logic now,
                                       input logic up,
                                       input logic down);
        logic hit;
        hit = 1'h0;
        case (sense)
            `SENSE_LEVEL: hit = (now == level);
            `SENSE_FALL: hit = down;
            `SENSE_RISE: hit = up;
            `SENSE_BOTH: hit = up | down;
            default: hit = 1'h0;
        endcase
        return hit;
    endfunction

    // The lhs side carries the negative input, so a lower lhs means a 1, or a 0 with invert set.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            result_r <= `FLAG_RESET;
            prev_r <= `FLAG_RESET;
        end else begin
            result_r <= (lhs < rhs) ^ ctl.invert; // [R01]
            prev_r <= result_r;
        end
    end

    // Edges come from registered results, so they cannot glitch.
    always_comb begin
        rise = result_r & ~prev_r;
        fall = ~result_r & prev_r;
    end

    // Interrupt and trigger sensing use their own settings, so one can
    // follow rising edges while the other follows falling ones.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_evt_r <= `FLAG_RESET;
            trig_r <= `FLAG_RESET;
        end else begin
            irq_evt_r <= sense_hit(ctl.irq_sense, ctl.irq_level,
                                   result_r, rise, fall); // [R03]
            trig_r <= ctl.trig_en & sense_hit(ctl.trig_sense,
                ctl.trig_level, result_r, rise, fall); // [R03] [R04]
        end
    end

endmodule
`default_nettype wire

// *** src/analog_comparator_control.sv ***
// Contract
// [R01] Output 1 when negative input below positive.
// [R02] Negative from pin; positive pin, cmp0, reference.
// [R03] Interrupt and trigger sensing chosen independently.
// [R04] Output reaches pin, interrupt, or converter trigger.
// [R05] Two independent comparators, own settings and status.
// [R06] Software sets source before trusting the output.
// [R07] Ladder disabled gives ground reference.
// [R08] Range 0: 31 R, AVDD times (tap+8)/31.
// [R09] Range 1: 23 R, AVDD times tap/23.
// [R10] Control, status, reference and three interrupt registers.
// [R11] Masked equals raw gated; write one clears.
// [R12] Interrupt forwarded only while enabled.
// [R13] Tap field four bits, values 0 to 15.
`timescale 1ns/1ns
`default_nettype none
`include "analog_comparator_control_map.svh"

// Digital control of two comparators and their shared reference ladder.
// Voltages arrive as unsigned codes from a front end on clk_sys.
module analog_comparator_control
    import analog_comparator_control_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] cmp0_positive_pin,
    input wire logic [W-1:0] cmp0_negative_pin,
    input wire logic [W-1:0] cmp1_positive_pin,
    input wire logic [W-1:0] cmp1_negative_pin,
    input wire logic [W-1:0] avdd_level,
    input wire comparator_ctl_type comparator_control_reg [2],
    input wire reference_ctl_type reference_control_reg,
    input wire logic [1:0] irq_enable_reg,
    input wire logic [1:0] irq_clear,
    output logic [1:0] comparator_status_reg,
    output logic [1:0] raw_irq_status,
    output logic [1:0] masked_irq_status,
    output logic irq_out,
    output logic cmp0_output_pin,
    output logic cmp0_output_pin_en,
    output logic [1:0] adc_trigger
);

    // Scaled width: a code times a five-bit ladder factor.
    localparam int SW = W + 5;

    logic [4:0] ref_num_r; // Resistance below the tap, in units.
    logic [4:0] ref_den_r; // Total ladder resistance, in units.
    logic [W-1:0] pos_pin [2]; // Own positive pins.
    logic [W-1:0] neg_pin [2]; // Own negative pins.
    logic [W-1:0] src_val [2]; // Selected positive source.
    logic [SW-1:0] lhs_w [2];  // Negative side after scaling.
    logic [SW-1:0] rhs_w [2];  // Positive side after scaling.
    logic [1:0] irq_evt;       // Event pulses or levels per comparator.
    logic [1:0] raw_nxt;       // Next raw interrupt status.

    // Gathers the pin codes into arrays indexed by comparator.
    always_comb begin
        pos_pin[0] = cmp0_positive_pin;
        pos_pin[1] = cmp1_positive_pin;
        neg_pin[0] = cmp0_negative_pin;
        neg_pin[1] = cmp1_negative_pin;
    end

    // Ladder ratio. A disabled ladder is a zero numerator, so the
    // reference is ground whatever range and tap say. The ratio is kept
    // as numerator and denominator to avoid a divider in the compare.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ref_num_r <= `LADDER_NUM_RESET;
            ref_den_r <= `LADDER_DEN_RESET;
        end else if (!reference_control_reg.en) begin
            ref_num_r <= `LADDER_NUM_RESET; // [R07]
            ref_den_r <= `UNITY_FACTOR;
        end else if (reference_control_reg.reference_range_select
                     != `RANGE_HIGH) begin
            // Four-bit tap lifted by the eight units below the ladder.
            ref_num_r <= 5'(reference_control_reg.tap)
                         + `LADDER_LO_OFFSET; // [R08] [R13]
            ref_den_r <= `LADDER_LO_TOTAL; // [R08]
        end else begin
            ref_num_r <= 5'(reference_control_reg.tap); // [R09] [R13]
            ref_den_r <= `LADDER_HI_TOTAL; // [R09]
        end
    end

    // Source selection and scaling. The negative input is always the
    // own pin. For the reference the test is neg * total < avdd * tap
    // units, which equals neg < reference without rounding loss.
    // Source code 0 selects the own pin, so an unprogrammed comparator
    // still gives a defined, if unintended, result.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            case (comparator_control_reg[i].positive_source_select)
                `SRC_OWN_PIN: src_val[i] = pos_pin[i]; // [R02] [R06]
                `SRC_CMP0_PIN: src_val[i] = cmp0_positive_pin; // [R02]
                `SRC_REFERENCE: src_val[i] = avdd_level; // [R02]
                default: src_val[i] = pos_pin[i];
            endcase
            if (comparator_control_reg[i].positive_source_select
                == `SRC_REFERENCE) begin
                lhs_w[i] = SW'(neg_pin[i]) * SW'(ref_den_r);
                rhs_w[i] = SW'(src_val[i]) * SW'(ref_num_r);
            end else begin
                lhs_w[i] = SW'(neg_pin[i]);
                rhs_w[i] = SW'(src_val[i]);
            end
        end
    end

    // Each comparator has its own channel, settings and status bit.
    for (genvar g = 0; g < 2; g++) begin : gen_ch
        comparator_channel #(
            .SW(SW)
        ) u_ch (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .lhs(lhs_w[g]),
            .rhs(rhs_w[g]),
            .ctl(comparator_control_reg[g]), // [R05]
            .result_r(comparator_status_reg[g]), // [R10]
            .irq_evt_r(irq_evt[g]),
            .trig_r(adc_trigger[g]) // [R04]
        );
    end

    // Raw status is sticky; a clear in the same cycle as an event
    // loses, so no event can slip past software.
    always_comb begin
        raw_nxt = irq_evt | (raw_irq_status & ~irq_clear); // [R11]
    end

    // Raw, masked and the combined line are all registered together.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            raw_irq_status <= `PAIR_RESET;
            masked_irq_status <= `PAIR_RESET;
            irq_out <= `FLAG_RESET;
        end else begin
            raw_irq_status <= raw_nxt; // [R10]
            masked_irq_status <= raw_nxt & irq_enable_reg; // [R11]
            irq_out <= |(raw_nxt & irq_enable_reg); // [R12]
        end
    end

    // Only comparator 0 has an output pin. It trails the status bit by
    // one cycle, the price of driving the pin from its own flip-flop.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmp0_output_pin <= `FLAG_RESET;
            cmp0_output_pin_en <= `FLAG_RESET;
        end else begin
            cmp0_output_pin <= comparator_status_reg[0]; // [R04]
            cmp0_output_pin_en <= comparator_control_reg[0].pin_en;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_rise0;
        !comparator_status_reg[0] ##1 comparator_status_reg[0];
    endsequence

    sequence s_fall0;
        comparator_status_reg[0] ##1 !comparator_status_reg[0];
    endsequence

    property p_below;
        (lhs_w[0] < rhs_w[0]) && !comparator_control_reg[0].invert
        |=> comparator_status_reg[0];
    endproperty
    a_below: assert property (p_below) // [R01]
        else $error("Result not 1 with negative below positive.");

    property p_above;
        (lhs_w[1] > rhs_w[1]) && !comparator_control_reg[1].invert
        |=> !comparator_status_reg[1];
    endproperty
    a_above: assert property (p_above) // [R01]
        else $error("Result not 0 with negative above positive.");

    property p_cmp0_src;
        comparator_control_reg[1].positive_source_select == `SRC_CMP0_PIN
        |-> rhs_w[1] == SW'(cmp0_positive_pin);
    endproperty
    a_cmp0_src: assert property (p_cmp0_src) // [R02]
        else $error("Comparator 1 not fed from comparator 0 pin.");

    property p_trig_rise;
        s_rise0 ##0 (comparator_control_reg[0].trig_sense == `SENSE_RISE
                     && comparator_control_reg[0].trig_en)
        |=> adc_trigger[0];
    endproperty
    a_trig_rise: assert property (p_trig_rise) // [R03]
        else $error("Rising edge gave no converter trigger.");

    property p_irq_fall;
        s_fall0 ##0 (comparator_control_reg[0].irq_sense == `SENSE_FALL)
        |=> ##1 raw_irq_status[0];
    endproperty
    a_irq_fall: assert property (p_irq_fall) // [R03]
        else $error("Falling edge gave no raw interrupt.");

    property p_trig_off;
        !comparator_control_reg[1].trig_en |=> !adc_trigger[1];
    endproperty
    a_trig_off: assert property (p_trig_off) // [R04]
        else $error("Trigger fired while disabled.");

    property p_ref_off;
        !reference_control_reg.en |=> ref_num_r == `LADDER_NUM_RESET;
    endproperty
    a_ref_off: assert property (p_ref_off) // [R07]
        else $error("Disabled ladder not at ground.");

    property p_range_lo;
        reference_control_reg.en
        && !reference_control_reg.reference_range_select
        |=> ref_den_r == `LADDER_LO_TOTAL && ref_num_r ==
            5'($past(reference_control_reg.tap)) + `LADDER_LO_OFFSET;
    endproperty
    a_range_lo: assert property (p_range_lo) // [R08]
        else $error("Low range ladder ratio wrong.");

    property p_range_hi;
        reference_control_reg.en
        && reference_control_reg.reference_range_select
        |=> ref_den_r == `LADDER_HI_TOTAL &&
            ref_num_r == 5'($past(reference_control_reg.tap));
    endproperty
    a_range_hi: assert property (p_range_hi) // [R09]
        else $error("High range ladder ratio wrong.");

    property p_set_wins;
        irq_evt[1] |=> raw_irq_status[1];
    endproperty
    a_set_wins: assert property (p_set_wins) // [R11]
        else $error("Interrupt event lost.");

    property p_clear;
        irq_clear[0] && !irq_evt[0] |=> !raw_irq_status[0];
    endproperty
    a_clear: assert property (p_clear) // [R11]
        else $error("Clear did not drop raw status.");

    property p_masked;
        masked_irq_status == (raw_irq_status & $past(irq_enable_reg))
        && irq_out == |masked_irq_status;
    endproperty
    a_masked: assert property (p_masked) // [R12]
        else $error("Masked status or interrupt line not gated.");

endmodule
`default_nettype wire

// *** tb/analog_front_end.sv ***
`timescale 1ns/1ns
`default_nettype none

// Far side: the analog pins and the supply, seen as codes on clk_sys.
module analog_front_end #(
    parameter int W = 12
) (
    input wire logic clk_sys,
    input wire logic narrow,
    output logic [W-1:0] p0,
    output logic [W-1:0] n0,
    output logic [W-1:0] p1,
    output logic [W-1:0] n1,
    output logic [W-1:0] avdd
);
    // Own seed, so the pin traffic does not disturb the bench's stream.
    int seed = 31;
    // Narrow codes make equal inputs common, the awkward compare case.
    initial begin
        {p0, n0, p1, n1, avdd} = '0;
        forever begin
            @(posedge clk_sys);
            #1;
            p0 = narrow ? W'($random(seed) & 3) : W'($random(seed));
            n0 = narrow ? W'($random(seed) & 3) : W'($random(seed));
            p1 = narrow ? W'($random(seed) & 3) : W'($random(seed));
            n1 = narrow ? W'($random(seed) & 3) : W'($random(seed));
            avdd = W'($random(seed));
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "analog_comparator_control_map.svh"

// Cycle model of the comparator pair, compared at every falling edge.
module tb_top
    import analog_comparator_control_pkg::*;
;
    localparam int W = 12;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic narrow = 1'h0;
    logic [W-1:0] p0, n0, p1, n1, avdd;
    comparator_ctl_type ctl [2];
    reference_ctl_type refc = '0;
    logic [1:0] irq_en = 2'h0;
    logic [1:0] irq_clear = 2'h0;
    logic [1:0] status, raw, masked, trig;
    logic irq_out, pin, pin_en;
    int seed = 31;
    int fails = 0;
    int n_tests = 0;
    // Model state, updated with blocking writes in dependency order.
    logic [1:0] m_res, m_resd, m_ievt, m_trig, m_raw, m_mask;
    logic m_irq, m_pin, m_pen;
    int m_num, m_den;

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

    always #4 clk_sys = ~clk_sys;

    analog_front_end #(.W(W)) fe (.clk_sys(clk_sys), .narrow(narrow),
        .p0(p0), .n0(n0), .p1(p1), .n1(n1), .avdd(avdd));

    analog_comparator_control #(.W(W)) uut (.clk_sys(clk_sys), .rstn(rstn),
        .cmp0_positive_pin(p0), .cmp0_negative_pin(n0),
        .cmp1_positive_pin(p1), .cmp1_negative_pin(n1), .avdd_level(avdd),
        .comparator_control_reg(ctl), .reference_control_reg(refc),
        .irq_enable_reg(irq_en), .irq_clear(irq_clear),
        .comparator_status_reg(status), .raw_irq_status(raw),
        .masked_irq_status(masked), .irq_out(irq_out),
        .cmp0_output_pin(pin), .cmp0_output_pin_en(pin_en),
        .adc_trigger(trig));

    // One sense decision, shared by the interrupt and trigger paths.
    function automatic logic hit(logic [1:0] s, logic lv, logic nw, logic od);
        case (s)
            `SENSE_LEVEL: return nw == lv;
            `SENSE_FALL: return od & ~nw;
            `SENSE_RISE: return ~od & nw;
            default: return nw ^ od;
        endcase
    endfunction

    // Comparator decision; the ladder uses last edge's num and den.
    function automatic logic decide(int i);
        int neg, pos;
        neg = (i == 0) ? int'(n0) : int'(n1);
        pos = (i == 0) ? int'(p0) : int'(p1);
        if (ctl[i].positive_source_select == `SRC_CMP0_PIN) begin
            pos = int'(p0);
        end
        if (ctl[i].positive_source_select == `SRC_REFERENCE) begin
            return (neg * m_den < int'(avdd) * m_num) ^ ctl[i].invert;
        end
        return (neg < pos) ^ ctl[i].invert;
    endfunction

    // Reference model, advanced on the same edges as the design.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {m_res, m_resd, m_ievt, m_trig, m_raw, m_mask} = '0;
            {m_irq, m_pin, m_pen} = '0;
            m_num = 0;
            m_den = 1;
        end else begin
            for (int i = 0; i < 2; i++) begin
                m_raw[i] = (m_raw[i] & ~irq_clear[i]) | m_ievt[i];
                m_ievt[i] = hit(ctl[i].irq_sense, ctl[i].irq_level,
                    m_res[i], m_resd[i]);
                m_trig[i] = ctl[i].trig_en & hit(ctl[i].trig_sense,
                    ctl[i].trig_level, m_res[i], m_resd[i]);
            end
            m_mask = m_raw & irq_en;
            m_irq = |m_mask;
            m_pin = m_res[0];
            m_pen = ctl[0].pin_en;
            m_resd = m_res;
            for (int i = 0; i < 2; i++) begin
                m_res[i] = decide(i);
            end
            // Ladder: disabled means ground, else the tap (plus 8 in range 0) over the ladder total.
            if (!refc.en) begin
                m_num = 0;
                m_den = 1;
            end else if (refc.reference_range_select) begin
                m_num = int'(refc.tap);
                m_den = 23;
            end else begin
                m_num = int'(refc.tap) + 8;
                m_den = 31;
            end
        end
    end

    // Outputs are settled by the falling edge. Checks run during reset
    // too, so a reset that leaves an output high is caught.
    always @(negedge clk_sys) begin
        `CHK("status", m_res, status)
        `CHK("raw", m_raw, raw)
        `CHK("masked", m_mask, masked)
        `CHK("irq_out", m_irq, irq_out)
        `CHK("trigger", m_trig, trig)
        `CHK("pin", m_pin, pin)
        `CHK("pin_en", m_pen, pin_en)
    end

    // Single exit point for both the normal end and the watchdog.
    task automatic summarize();
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // About 2000 cycles are expected; this allows a wide margin.
    initial begin
        #400000;
        fails++;
        summarize();
    end

    // Each phase walks source and sense codes and alternates narrow; the rest is random.
    initial begin
        ctl[0] = '0;
        ctl[1] = '0;
        repeat (3) @(posedge clk_sys);
        #1 rstn = 1'h1;
        for (int p = 0; p < 32; p++) begin
            @(posedge clk_sys);
            #1;
            for (int i = 0; i < 2; i++) begin
                ctl[i] = comparator_ctl_type'($random(seed));
                ctl[i].positive_source_select = 2'((p / 4 + i) % 4);
                ctl[i].irq_sense = 2'(p % 4);
                ctl[i].trig_sense = 2'((p + i + 1) % 4);
            end
            refc = reference_ctl_type'($random(seed));
            // Tap boundaries are forced on some phases.
            if (p % 8 == 3) refc.tap = 4'h0;
            if (p % 8 == 7) refc.tap = 4'hF;
            irq_en = 2'($random(seed));
            narrow = p[0];
            // A reset in mid-run must return every output to zero.
            if (p == 16) begin
                rstn = 1'h0;
                repeat (2) @(posedge clk_sys);
                #1 rstn = 1'h1;
            end
            repeat (60) begin
                @(posedge clk_sys);
                #1;
                irq_clear = (($random(seed) & 7) == 0) ? 2'($random(seed))
                    : 2'h0;
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
